/* File: shared/ascp_params.svh */
`ifndef ASCP_PARAMS_SVH
`define ASCP_PARAMS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ASCP_ADDR_SOFT_INIT 8'h00
`define ASCP_ADDR_CLK_DRV 8'h10
`define ASCP_ADDR_OUT_CUR 8'h11
`define ASCP_ADDR_TERM 8'h12
`define ASCP_ADDR_OFS_HOLD 8'h13
`define ASCP_ADDR_IF_PWR 8'h14
`define ASCP_ADDR_FMT 8'h16
`define ASCP_ADDR_FINE_GAIN 8'h17
`define ASCP_ADDR_PAT_LO 8'h18
`define ASCP_ADDR_PAT_HI 8'h19
`define ASCP_ADDR_LAT 8'h1A
`define ASCP_ADDR_FILT 8'h1B
`define ASCP_ADDR_DEC_BAND 8'h1D
`define ASCP_ADDR_TAP_FIRST 8'h1E
`define ASCP_ADDR_TAP_LAST 8'h2F
`define ASCP_TAP_BYTES 18
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ASCP_SOFT_INIT_BIT 1
`define ASCP_OFS_HOLD_BIT 4
`define ASCP_PIN_PRIO_BIT 7
`define ASCP_IF_SEL_BIT 5
`define ASCP_REG_RESET 8'h00
`define ASCP_WORD_BITS 16
`define ASCP_BITCNT_W 4
`endif

/* File: shared/ascp_pkg.sv */
package ascp_pkg;
	typedef enum logic [1:0] {ASCP_LVL_GND, ASCP_LVL_3_8, ASCP_LVL_5_8, ASCP_LVL_FULL} ascp_level_e;
	typedef logic [7:0] ascp_byte_t;
endpackage : ascp_pkg

/* File: hdl/ascp_config_port.sv */
// How it works
// - Sample data bit on each falling shift-clock edge while enable is low.
// - Every sixteenth falling edge in one enable period commits the word.
// - Trailing partial word at enable rise is discarded, no write.
// - Many words may follow back to back in one enable period.
// - First eight bits are address, next eight bits are data.
// - Shift clock up to 20 MHz, any lower rate, any duty cycle; with 20 MHz sampling each level must last 50 ns or more.
// - Reset pulse over 10 ns returns all registers to defaults; here it must span a 50 ns sample and is ignored in pin mode.
// - Writing one to bit 1 at address 00 resets registers, self-clears.
// - Pin priority zero: mode pins rule; one: register field rules.
// - Mode code pin1 MSB: normal, A off, B off, both off, down, A standby, B standby, interleave.
// - Interleave multiplexes both channels on one 12-bit bus, single-ended only.
// - After power-up, mode pins configure the device without serial writes.
// - Enable pin level picks data format and output interface in pin mode.
// - Shift clock pin level picks gain and reference in pin mode.
// - Address 10 bits 7:6 set output clock driver strength.
// - Address 11 bits 1:0 set output data driver strength.
// - Address 11 bits 3:2 current, bits 5:4 current doubling.
// - Address 12 bits 5:3 data termination, bits 2:0 clock termination.
// - Address 13 bit 4 freezes offset estimate, keeps last value.
// - Addresses 1E to 2F hold twelve 12-bit signed filter taps.
// - Address 14 bits 2:0 power field uses the mode pin codes.
// - Address 14 bit 7 lets register power field override mode pins; interface bit 5 rules whenever not in pin mode.
`timescale 1ns/10ps
`default_nettype none
`include "ascp_params.svh"
module ascp_config_port
	import ascp_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reg_reset,
	input wire logic serial_enable_n,
	input wire logic serial_clock,
	input wire logic serial_input_bit,
	input wire logic mode_pin_1,
	input wire logic mode_pin_2,
	input wire logic mode_pin_3,
	input wire logic parallel_pin_mode,
	input wire logic [1:0] enable_pin_level,
	input wire logic [1:0] clock_pin_level,
	output logic [1:0] clk_drive_strength,
	output logic [1:0] data_drive_strength,
	output logic [1:0] driver_current,
	output logic [1:0] current_double,
	output logic [2:0] data_termination,
	output logic [2:0] clock_termination,
	output logic offset_hold,
	output logic [2:0] power_mode,
	output logic channel_a_out_off,
	output logic channel_b_out_off,
	output logic global_power_down,
	output logic channel_a_standby,
	output logic channel_b_standby,
	output logic channel_interleave,
	output logic lvds_select,
	output logic twos_complement,
	output logic coarse_gain_35db,
	output logic external_reference,
	output logic [7:0] format_reg,
	output logic [7:0] fine_gain_reg,
	output logic [7:0] pattern_lo_reg,
	output logic [7:0] pattern_hi_reg,
	output logic [7:0] latency_reg,
	output logic [7:0] filter_reg,
	output logic [7:0] dec_band_reg,
	output logic [8*`ASCP_TAP_BYTES-1:0] tap_bytes
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [4:0] msync1_r;
	logic [4:0] msync2_r;
	logic rst_sync1_r;
	logic rst_sync2_r;
	logic [1:0] lvl_sync1_r;
	logic [1:0] lvl_sync2_r;
	logic sclk_prev_r;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1_r <= 3'h7;
			sync2_r <= 3'h7;
			msync1_r <= 5'h00;
			msync2_r <= 5'h00;
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
			lvl_sync1_r <= 2'h0;
			lvl_sync2_r <= 2'h0;
			sclk_prev_r <= 1'b1;
		end else begin
			sync1_r <= {serial_enable_n, serial_clock, serial_input_bit};
			sync2_r <= sync1_r;
			msync1_r <= {mode_pin_1, mode_pin_2, mode_pin_3, enable_pin_level};
			msync2_r <= msync1_r;
			rst_sync1_r <= reg_reset;
			rst_sync2_r <= rst_sync1_r;
			lvl_sync1_r <= clock_pin_level;
			lvl_sync2_r <= lvl_sync1_r;
			sclk_prev_r <= sync2_r[1];
		end
	end
	wire sen_n_s = sync2_r[2];
	wire sclk_s = sync2_r[1];
	wire serial_input_bit_s = sync2_r[0];
	wire [2:0] pin_mode_code = msync2_r[4:2];
	wire [1:0] pin_fmt_level = msync2_r[1:0];
	wire [1:0] pin_gain_level = lvl_sync2_r;
	// Edge found at 20 MHz sampling; a 10 MHz shift clock relies on its
	// 50 ns high and low phases, slower clocks have ample margin.
	wire sclk_fall = sclk_prev_r && !sclk_s;
	// Reset pin is only meaningful in serial mode; parallel mode masks it and holds hw_reset low
	wire hw_reset = rst_sync2_r && !parallel_pin_mode;
	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic [14:0] shift_r;
	logic [`ASCP_BITCNT_W-1:0] bitcnt_r;
	wire shift_bit = sclk_fall && !sen_n_s && !parallel_pin_mode;
	wire word_done = shift_bit && (bitcnt_r == 4'hF);
	wire [15:0] word = {shift_r, serial_input_bit_s};
	wire [7:0] waddr = word[15:8];
	wire [7:0] wdata = word[7:0];
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			shift_r <= 15'h0000;
			bitcnt_r <= 4'h0;
		end else if (sen_n_s) begin
			bitcnt_r <= 4'h0;
		end else if (shift_bit) begin
			shift_r <= word[14:0];
			bitcnt_r <= bitcnt_r + 4'h1;
		end
	end
	// ----------------------------------------
	// Register bank
	// ----------------------------------------
	logic soft_init_r;
	logic [7:0] clk_drv_r;
	logic [7:0] out_cur_r;
	logic [7:0] term_r;
	logic [7:0] ofs_hold_r;
	logic [7:0] if_pwr_r;
	logic [7:0] fmt_r;
	logic [7:0] fine_gain_r;
	logic [7:0] pat_lo_r;
	logic [7:0] pat_hi_r;
	logic [7:0] lat_r;
	logic [7:0] filt_r;
	logic [7:0] dec_band_r;
	wire soft_init_nxt = word_done && (waddr == `ASCP_ADDR_SOFT_INIT) && wdata[`ASCP_SOFT_INIT_BIT];
	wire clear_all = hw_reset || soft_init_r;
	wire wr_clk_drv = word_done && (waddr == `ASCP_ADDR_CLK_DRV);
	wire wr_out_cur = word_done && (waddr == `ASCP_ADDR_OUT_CUR);
	wire wr_term = word_done && (waddr == `ASCP_ADDR_TERM);
	wire wr_ofs = word_done && (waddr == `ASCP_ADDR_OFS_HOLD);
	wire wr_if_pwr = word_done && (waddr == `ASCP_ADDR_IF_PWR);
	wire wr_fmt = word_done && (waddr == `ASCP_ADDR_FMT);
	wire wr_fine = word_done && (waddr == `ASCP_ADDR_FINE_GAIN);
	wire wr_pat_lo = word_done && (waddr == `ASCP_ADDR_PAT_LO);
	wire wr_pat_hi = word_done && (waddr == `ASCP_ADDR_PAT_HI);
	wire wr_lat = word_done && (waddr == `ASCP_ADDR_LAT);
	wire wr_filt = word_done && (waddr == `ASCP_ADDR_FILT);
	wire wr_dec = word_done && (waddr == `ASCP_ADDR_DEC_BAND);
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			soft_init_r <= 1'b0;
		end else begin
			soft_init_r <= soft_init_nxt;
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n || clear_all) begin
			clk_drv_r <= `ASCP_REG_RESET;
			out_cur_r <= `ASCP_REG_RESET;
			term_r <= `ASCP_REG_RESET;
			ofs_hold_r <= `ASCP_REG_RESET;
			if_pwr_r <= `ASCP_REG_RESET;
			fmt_r <= `ASCP_REG_RESET;
			fine_gain_r <= `ASCP_REG_RESET;
			pat_lo_r <= `ASCP_REG_RESET;
			pat_hi_r <= `ASCP_REG_RESET;
			lat_r <= `ASCP_REG_RESET;
			filt_r <= `ASCP_REG_RESET;
			dec_band_r <= `ASCP_REG_RESET;
		end else begin
			if (wr_clk_drv) clk_drv_r <= wdata;
			if (wr_out_cur) out_cur_r <= wdata;
			if (wr_term) term_r <= wdata;
			if (wr_ofs) ofs_hold_r <= wdata;
			if (wr_if_pwr) if_pwr_r <= wdata;
			if (wr_fmt) fmt_r <= wdata;
			if (wr_fine) fine_gain_r <= wdata;
			if (wr_pat_lo) pat_lo_r <= wdata;
			if (wr_pat_hi) pat_hi_r <= wdata;
			if (wr_lat) lat_r <= wdata;
			if (wr_filt) filt_r <= wdata;
			if (wr_dec) dec_band_r <= wdata;
		end
	end
	// ----------------------------------------
	// Filter tap bytes, one per address
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `ASCP_TAP_BYTES; gi = gi + 1) begin : g_tap
			logic [7:0] tap_r;
			wire wr_tap = word_done && (waddr == (`ASCP_ADDR_TAP_FIRST + 8'(gi)));
			always_ff @(posedge clk) begin
				if (!reset_n || clear_all) begin
					tap_r <= `ASCP_REG_RESET;
				end else if (wr_tap) begin
					tap_r <= wdata;
				end
			end
			assign tap_bytes[8*gi +: 8] = tap_r;
		end
	endgenerate
	// ----------------------------------------
	// Field decode and pin priority
	// ----------------------------------------
	wire pin_prio = if_pwr_r[`ASCP_PIN_PRIO_BIT];
	// Serial mode has no analog levels on the shared pins; register fields hold
	wire [2:0] mode_code = pin_prio ? if_pwr_r[2:0] : pin_mode_code;
	wire pin_lvds = (pin_fmt_level == ASCP_LVL_GND) || (pin_fmt_level == ASCP_LVL_3_8);
	wire pin_twos = (pin_fmt_level == ASCP_LVL_GND) || (pin_fmt_level == ASCP_LVL_FULL);
	wire pin_gain = (pin_gain_level == ASCP_LVL_5_8) || (pin_gain_level == ASCP_LVL_FULL);
	wire pin_ext = (pin_gain_level == ASCP_LVL_3_8) || (pin_gain_level == ASCP_LVL_5_8);
	wire reg_lvds = if_pwr_r[`ASCP_IF_SEL_BIT];
	wire lvds_nxt = parallel_pin_mode ? pin_lvds : (pin_prio ? reg_lvds : reg_lvds);
	// Interleave is only legal on the single-ended bus
	wire mux_nxt = (mode_code == 3'h7) && !lvds_nxt;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			power_mode <= 3'h0;
			channel_a_out_off <= 1'b0;
			channel_b_out_off <= 1'b0;
			global_power_down <= 1'b0;
			channel_a_standby <= 1'b0;
			channel_b_standby <= 1'b0;
			channel_interleave <= 1'b0;
			lvds_select <= 1'b0;
			twos_complement <= 1'b0;
			coarse_gain_35db <= 1'b0;
			external_reference <= 1'b0;
		end else begin
			power_mode <= mode_code;
			channel_a_out_off <= (mode_code == 3'h1) || (mode_code == 3'h3);
			channel_b_out_off <= (mode_code == 3'h2) || (mode_code == 3'h3);
			global_power_down <= (mode_code == 3'h4);
			channel_a_standby <= (mode_code == 3'h5);
			channel_b_standby <= (mode_code == 3'h6);
			channel_interleave <= mux_nxt;
			lvds_select <= lvds_nxt;
			twos_complement <= parallel_pin_mode ? pin_twos : !fmt_r[4];
			coarse_gain_35db <= parallel_pin_mode ? pin_gain : if_pwr_r[4];
			external_reference <= parallel_pin_mode ? pin_ext : if_pwr_r[3];
		end
	end
	assign clk_drive_strength = clk_drv_r[7:6];
	assign data_drive_strength = out_cur_r[1:0];
	assign driver_current = out_cur_r[3:2];
	assign current_double = out_cur_r[5:4];
	assign data_termination = term_r[5:3];
	assign clock_termination = term_r[2:0];
	assign offset_hold = ofs_hold_r[`ASCP_OFS_HOLD_BIT];
	assign format_reg = fmt_r;
	assign fine_gain_reg = fine_gain_r;
	assign pattern_lo_reg = pat_lo_r;
	assign pattern_hi_reg = pat_hi_r;
	assign latency_reg = lat_r;
	assign filter_reg = filt_r;
	assign dec_band_reg = dec_band_r;
endmodule : ascp_config_port
`default_nettype wire

/* File: tb/ascp_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ascp_params.svh"
module ascp_checker
	import ascp_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reg_reset,
	input wire logic serial_enable_n,
	input wire logic mode_pin_1,
	input wire logic mode_pin_2,
	input wire logic mode_pin_3,
	input wire logic parallel_pin_mode,
	input wire logic [1:0] enable_pin_level,
	input wire logic [1:0] clock_pin_level,
	input wire logic [1:0] clk_drive_strength,
	input wire logic [2:0] data_termination,
	input wire logic [8*`ASCP_TAP_BYTES-1:0] tap_bytes,
	input wire logic [2:0] power_mode,
	input wire logic global_power_down,
	input wire logic channel_interleave,
	input wire logic lvds_select,
	input wire logic twos_complement,
	input wire logic coarse_gain_35db,
	input wire logic external_reference
);
	// ----------------------------------------
	// Quiet counter: cycles since the link was last active
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [3:0] quiet_r;
	always_ff @(posedge clk) begin
		if (!reset_n || reg_reset || !serial_enable_n) quiet_r <= 4'h0;
		else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
	end
	// Pin paths pass two sync flops and a decode flop, so six cycles of steady input suffice
	property p_reset_clear; $rose(reset_n) |-> clk_drive_strength == 2'h0 && tap_bytes == '0 && power_mode == 3'h0; endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");
	property p_pin_clear; $rose(reg_reset) && !parallel_pin_mode |-> ##[1:5] data_termination == 3'h0 && tap_bytes == '0; endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("reset pin did not clear registers");
	property p_idle_hold; quiet_r == 4'hF |-> $stable(clk_drive_strength) && $stable(data_termination) && $stable(tap_bytes); endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("register changed with link idle");
	property p_pd_code; power_mode == 3'h4 [*2] |-> global_power_down && !channel_interleave; endproperty
	a_pd_code: assert property (p_pd_code) else $error("power-down code not decoded");
	property p_no_mux_lvds; lvds_select [*2] |-> !channel_interleave; endproperty
	a_no_mux_lvds: assert property (p_no_mux_lvds) else $error("interleave with differential output");
	property p_pin_fmt; (parallel_pin_mode && enable_pin_level == ASCP_LVL_GND) [*6] |-> lvds_select && twos_complement; endproperty
	a_pin_fmt: assert property (p_pin_fmt) else $error("format level not applied");
	property p_pin_gain; (parallel_pin_mode && clock_pin_level == ASCP_LVL_FULL) [*6] |-> coarse_gain_35db && !external_reference; endproperty
	a_pin_gain: assert property (p_pin_gain) else $error("gain level not applied");
	property p_pin_mode; (parallel_pin_mode && {mode_pin_1, mode_pin_2, mode_pin_3} == 3'h7) [*6] |-> power_mode == 3'h7; endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("mode pins not applied");
	c_mux: cover property (channel_interleave);
	c_pd: cover property (global_power_down);
	c_wake: cover property (quiet_r == 4'hF ##1 !serial_enable_n);
endmodule : ascp_checker
bind ascp_config_port ascp_checker chk_u (.clk, .reset_n, .reg_reset, .serial_enable_n, .mode_pin_1, .mode_pin_2,
	.mode_pin_3, .parallel_pin_mode, .enable_pin_level, .clock_pin_level, .clk_drive_strength, .data_termination,
	.tap_bytes, .power_mode, .global_power_down, .channel_interleave, .lvds_select, .twos_complement,
	.coarse_gain_35db, .external_reference);
`default_nettype wire

/* File: tb/ascp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ascp_host_model (
	output logic serial_enable_n,
	output logic serial_clock,
	output logic serial_input_bit
);
	// ----------------------------------------
	// Shift clock parks high and runs only inside a frame
	// ----------------------------------------
	initial begin
		serial_enable_n = 1'b1;
		serial_clock = 1'b1;
		serial_input_bit = 1'b0;
	end
	task automatic send(input logic [63:0] v, input int n);
		// Enable stays high long enough for the synced copy to see it between frames
		#300;
		serial_enable_n = 1'b0;
		#100;
		for (int i = n - 1; i >= 0; i--) begin
			serial_input_bit = v[i];
			#200;
			serial_clock = 1'b0;
			#200;
			serial_clock = 1'b1;
		end
		#300;
		serial_enable_n = 1'b1;
		// Released data line shows a changed level, never the held one
		serial_input_bit = ~serial_input_bit;
	endtask : send
endmodule : ascp_host_model
`default_nettype wire

/* File: tb/test_ascp_config_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ascp_params.svh"
module test_ascp_config_port;
	import ascp_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, reg_reset = 1'b0, parallel_pin_mode = 1'b0;
	logic mode_pin_1 = 1'b0, mode_pin_2 = 1'b0, mode_pin_3 = 1'b0;
	logic [1:0] enable_pin_level = 2'h0, clock_pin_level = 2'h0;
	wire logic serial_enable_n, serial_clock, serial_input_bit;
	logic [1:0] clk_drive_strength, data_drive_strength, driver_current, current_double;
	logic [2:0] data_termination, clock_termination, power_mode;
	logic offset_hold, global_power_down, channel_a_standby, channel_interleave;
	logic lvds_select, twos_complement, coarse_gain_35db, external_reference;
	logic [7:0] fine_gain_reg;
	logic [8*`ASCP_TAP_BYTES-1:0] tap_bytes;
	int err_total = 0;
	int tests_run = 0;
	ascp_host_model host_u (.serial_enable_n, .serial_clock, .serial_input_bit);
	ascp_config_port dut_u (.clk, .reset_n, .reg_reset, .serial_enable_n, .serial_clock, .serial_input_bit,
		.mode_pin_1, .mode_pin_2, .mode_pin_3, .parallel_pin_mode, .enable_pin_level, .clock_pin_level,
		.clk_drive_strength, .data_drive_strength, .driver_current, .current_double, .data_termination,
		.clock_termination, .offset_hold, .power_mode, .channel_a_out_off(), .channel_b_out_off(),
		.global_power_down, .channel_a_standby, .channel_b_standby(), .channel_interleave, .lvds_select,
		.twos_complement, .coarse_gain_35db, .external_reference, .format_reg(), .fine_gain_reg,
		.pattern_lo_reg(), .pattern_hi_reg(), .latency_reg(), .filter_reg(), .dec_band_reg(), .tap_bytes);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	// Pin paths settle through sync and decode flops well inside eight cycles
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask : settle
	task automatic s_fields();
		host_u.send({16'h1080, 16'h112E, 16'h122B, 16'h1310}, 64);
		chk(clk_drive_strength, 8'h02);
		chk(data_drive_strength, 8'h02);
		chk(driver_current, 8'h03);
		chk(current_double, 8'h02);
		chk(data_termination, 8'h05);
		chk(clock_termination, 8'h03);
		chk(offset_hold, 8'h01);
		// Trailing byte aims at the clock strength register and must be dropped
		host_u.send(64'h17092FA510, 40);
		chk(fine_gain_reg, 8'h09);
		chk(tap_bytes[143:136], 8'hA5);
		chk(clk_drive_strength, 8'h02);
	endtask : s_fields
	task automatic s_resets();
		host_u.send(64'h0002, 16);
		chk(clk_drive_strength, 8'h00);
		chk(tap_bytes[143:136], 8'h00);
		host_u.send(64'h1080, 16);
		chk(clk_drive_strength, 8'h02);
		@(posedge clk);
		reg_reset <= 1'b1;
		@(posedge clk);
		reg_reset <= 1'b0;
		settle();
		chk(clk_drive_strength, 8'h00);
	endtask : s_resets
	task automatic s_modes();
		for (int c = 0; c < 8; c++) begin
			@(posedge clk);
			{mode_pin_1, mode_pin_2, mode_pin_3} <= 3'(c);
			settle();
			chk(power_mode, 8'(c));
			chk(global_power_down, 8'(c == 4));
			chk(channel_a_standby, 8'(c == 5));
			chk(channel_interleave, 8'(c == 7));
		end
		host_u.send(64'h1484, 16);
		chk(power_mode, 8'h04);
		host_u.send(64'h14A7, 16);
		chk(channel_interleave, 8'h00);
		host_u.send(64'h1400, 16);
		chk(power_mode, 8'h07);
	endtask : s_modes
	task automatic s_levels();
		@(posedge clk);
		parallel_pin_mode <= 1'b1;
		for (int l = 0; l < 4; l++) begin
			@(posedge clk);
			enable_pin_level <= 2'(l);
			clock_pin_level <= 2'(l);
			settle();
			chk(lvds_select, 8'(l < 2));
			chk(twos_complement, 8'(l == 0 || l == 3));
			chk(coarse_gain_35db, 8'(l > 1));
			chk(external_reference, 8'(l == 1 || l == 2));
		end
	endtask : s_levels
	initial begin
		// Supplies count as settled at time zero; the run starts from the reset pulse
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		settle();
		chk(clk_drive_strength, 8'h00);
		s_fields();
		s_resets();
		s_modes();
		s_levels();
		give_verdict();
	end
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
endmodule : test_ascp_config_port
`default_nettype wire
